// ==== shared/bsj_consts.svh ====
// Behaviour
// - 3-bit instruction register: shift stage plus latched instruction.
// - Shift-IR shifts the instruction stage toward the output each rise.
// - Rise into Update-IR: its falling edge latches the shift stage.
// - 010 sample/preload and 000 extest pick boundary; 111 bypass.
// - 011 clamp, 100 high-Z, 001 idcode; idcode picks identification.
// - Sample/preload captures pins in Capture-DR, shifts in Shift-DR.
// - Extest drives outputs from boundary latches and captures inputs.
// - Bypass routes serial data through one bypass stage.
// - Idcode loads the identification value in Capture-DR, shifts it out.
// - Test-Logic-Reset forces idcode into the current instruction.
// - Id value from LSB: 1, 11-bit maker, 16-bit device, 4-bit version.
// - High-Z floats all outputs and puts the bypass stage in the path.
// - Clamp holds outputs from boundary latches; bypass stage in path.
// - Boundary register: 126 cells, shift path and latched output.
// - Identification register: 32-bit shift stage and 32-bit latch.
// - Controller steps on test clock rises, per sampled mode select; test reset forces Test-Logic-Reset without a rise.
// - Capture-IR loads a fixed pattern into the instruction shift stage.
// - Update-DR fall copies the selected shift stage into its latches.
`ifndef BSJ_CONSTS_SVH
`define BSJ_CONSTS_SVH
// =====================================================
// instruction register
`define BSJ_IR_W        3
`define BSJ_OP_EXTEST   3'h0
`define BSJ_OP_IDCODE   3'h1
`define BSJ_OP_SAMPLE   3'h2
`define BSJ_OP_CLAMP    3'h3
`define BSJ_OP_HIGHZ    3'h4
`define BSJ_OP_BYPASS   3'h7
`define BSJ_IR_CAPTURE  3'h1
// =====================================================
// data registers
`define BSJ_BSR_LEN     126
`define BSJ_ID_W        32
// identity fields, values arbitrary
`define BSJ_ID_VERSION  4'h3
`define BSJ_ID_DEVICE   16'h5A5A
`define BSJ_ID_MAKER    11'h155
`endif

// ==== shared/bsj_pkg.sv ====
package bsj_pkg;
  // =====================================================
  // tap controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
    ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bsj_tap_e;
  // =====================================================
  // selected data register
  typedef enum logic [1:0] {SEL_BYP, SEL_BSR, SEL_IDR} bsj_dsel_e;
  // =====================================================
  // sampled link pins
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bsj_link_s;
endpackage

// ==== rtl/bsj_tap.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "bsj_consts.svh"
module bsj_tap
  import bsj_pkg::*;
#(
  parameter int BSR_LEN = `BSJ_BSR_LEN,
  parameter int ID_W    = `BSJ_ID_W
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // test access port
  input  wire logic               test_clock_in,
  input  wire logic               test_mode_select_in,
  input  wire logic               test_serial_in,
  input  wire logic               test_reset_n,
  output logic                    test_serial_out,
  output logic                    test_serial_out_oe_n,
  // device pins and core
  input  wire logic [BSR_LEN-1:0] pin_in,
  input  wire logic [BSR_LEN-1:0] core_out,
  input  wire logic               core_oe_n,
  output logic      [BSR_LEN-1:0] pin_out,
  output logic                    pin_oe_n,
  // identification latch
  output logic      [ID_W-1:0]    id_par_out
);
  // =====================================================
  // synchronisers
  bsj_link_s          link_m_q, link_s_q;
  logic               tck_prev_q;
  logic               trst_m_q, trst_s_q;
  logic [BSR_LEN-1:0] pin_m_q, pin_s_q;
  logic               trst_arst_n;
  logic               rise, fall;

  assign trst_arst_n = rst_b & test_reset_n;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      link_m_q   <= '0;
      link_s_q   <= '0;
      tck_prev_q <= 1'b0;
      pin_m_q    <= '0;
      pin_s_q    <= '0;
    end
    else
    begin
      link_m_q   <= {test_clock_in, test_mode_select_in, test_serial_in};
      link_s_q   <= link_m_q;
      tck_prev_q <= link_s_q.tck;
      pin_m_q    <= pin_in;
      pin_s_q    <= pin_m_q;
    end
  end

  // test reset asserts at once, releases through two flops
  always_ff @(posedge clk or negedge trst_arst_n)
  begin
    if (!trst_arst_n)
    begin
      trst_m_q <= 1'b0;
      trst_s_q <= 1'b0;
    end
    else
    begin
      trst_m_q <= 1'b1;
      trst_s_q <= trst_m_q;
    end
  end

  assign rise = link_s_q.tck & ~tck_prev_q;
  assign fall = ~link_s_q.tck & tck_prev_q;

  // =====================================================
  // tap controller and test registers
  localparam logic [ID_W-1:0] ID_VALUE =
    {`BSJ_ID_VERSION, `BSJ_ID_DEVICE, `BSJ_ID_MAKER, 1'b1};

  bsj_tap_e               st_q, st_d;
  logic [`BSJ_IR_W-1:0]   ir_sh_q, ir_sh_d, ir_par_q, ir_par_d;
  logic [BSR_LEN-1:0]     bsr_sh_q, bsr_sh_d, bsr_par_q, bsr_par_d;
  logic [ID_W-1:0]        idr_sh_q, idr_sh_d, idr_par_q, idr_par_d;
  logic                   byp_q, byp_d;
  logic                   tdo_q, tdo_d, tdo_oe_n_q, tdo_oe_n_d;
  bsj_dsel_e              dsel;
  logic                   tms;

  assign tms = link_s_q.tms;

  always_comb
  begin
    unique case (ir_par_q)
      `BSJ_OP_SAMPLE, `BSJ_OP_EXTEST: dsel = SEL_BSR;
      `BSJ_OP_IDCODE:                 dsel = SEL_IDR;
      default:                        dsel = SEL_BYP;
    endcase
  end

  always_comb
  begin
    st_d       = st_q;
    ir_sh_d    = ir_sh_q;
    ir_par_d   = ir_par_q;
    bsr_sh_d   = bsr_sh_q;
    bsr_par_d  = bsr_par_q;
    idr_sh_d   = idr_sh_q;
    idr_par_d  = idr_par_q;
    byp_d      = byp_q;
    tdo_d      = tdo_q;
    tdo_oe_n_d = tdo_oe_n_q;
    if (!trst_s_q)
    begin
      st_d       = ST_TLR;
      tdo_oe_n_d = 1'b1;
    end
    else if (rise)
    begin
      // next state from sampled mode select
      unique case (st_q)
        ST_TLR:    st_d = tms ? ST_TLR    : ST_RTI;
        ST_RTI:    st_d = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: st_d = tms ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: st_d = tms ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR:  st_d = tms ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: st_d = tms ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: st_d = tms ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: st_d = tms ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: st_d = tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: st_d = tms ? ST_TLR    : ST_CAP_IR;
        ST_CAP_IR: st_d = tms ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR:  st_d = tms ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: st_d = tms ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: st_d = tms ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: st_d = tms ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: st_d = tms ? ST_SEL_DR : ST_RTI;
      endcase
      if (st_q == ST_CAP_IR)
        ir_sh_d = `BSJ_IR_CAPTURE;
      if (st_q == ST_SH_IR)
        ir_sh_d = {link_s_q.tdi, ir_sh_q[`BSJ_IR_W-1:1]};
      if (st_q == ST_CAP_DR)
      begin
        unique case (dsel)
          SEL_BSR: bsr_sh_d = pin_s_q;
          SEL_IDR: idr_sh_d = ID_VALUE;
          SEL_BYP: byp_d    = 1'b0;
        endcase
      end
      if (st_q == ST_SH_DR)
      begin
        unique case (dsel)
          SEL_BSR: bsr_sh_d = {link_s_q.tdi, bsr_sh_q[BSR_LEN-1:1]};
          SEL_IDR: idr_sh_d = {link_s_q.tdi, idr_sh_q[ID_W-1:1]};
          SEL_BYP: byp_d    = link_s_q.tdi;
        endcase
      end
    end
    else if (fall)
    begin
      if (st_q == ST_UPD_IR)
        ir_par_d = ir_sh_q;
      if (st_q == ST_UPD_DR)
      begin
        unique case (dsel)
          SEL_BSR: bsr_par_d = bsr_sh_q;
          SEL_IDR: idr_par_d = idr_sh_q;
          SEL_BYP: byp_d     = byp_q;
        endcase
      end
      // serial output moves on the falling edge only
      tdo_oe_n_d = 1'b1;
      if (st_q == ST_SH_IR)
      begin
        tdo_d      = ir_sh_q[0];
        tdo_oe_n_d = 1'b0;
      end
      else if (st_q == ST_SH_DR)
      begin
        tdo_oe_n_d = 1'b0;
        unique case (dsel)
          SEL_BSR: tdo_d = bsr_sh_q[0];
          SEL_IDR: tdo_d = idr_sh_q[0];
          SEL_BYP: tdo_d = byp_q;
        endcase
      end
    end
    if (st_q == ST_TLR)
      ir_par_d = `BSJ_OP_IDCODE;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q       <= ST_TLR;
      ir_sh_q    <= '0;
      ir_par_q   <= `BSJ_OP_IDCODE;
      bsr_sh_q   <= '0;
      bsr_par_q  <= '0;
      idr_sh_q   <= '0;
      idr_par_q  <= '0;
      byp_q      <= 1'b0;
      tdo_q      <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end
    else
    begin
      st_q       <= st_d;
      ir_sh_q    <= ir_sh_d;
      ir_par_q   <= ir_par_d;
      bsr_sh_q   <= bsr_sh_d;
      bsr_par_q  <= bsr_par_d;
      idr_sh_q   <= idr_sh_d;
      idr_par_q  <= idr_par_d;
      byp_q      <= byp_d;
      tdo_q      <= tdo_d;
      tdo_oe_n_q <= tdo_oe_n_d;
    end
  end

  // =====================================================
  // pin drive
  logic [BSR_LEN-1:0] pin_out_q, pin_out_d;
  logic               pin_oe_n_q, pin_oe_n_d;
  logic               drive_bsr;

  assign drive_bsr = (ir_par_q == `BSJ_OP_EXTEST) ||
                     (ir_par_q == `BSJ_OP_CLAMP);

  always_comb
  begin
    pin_out_d  = drive_bsr ? bsr_par_q : core_out;
    pin_oe_n_d = drive_bsr ? 1'b0 : core_oe_n;
    if (ir_par_q == `BSJ_OP_HIGHZ)
      pin_oe_n_d = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_out_q  <= '0;
      pin_oe_n_q <= 1'b1;
    end
    else
    begin
      pin_out_q  <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  assign pin_out              = pin_out_q;
  assign pin_oe_n             = pin_oe_n_q;
  assign test_serial_out      = tdo_q;
  assign test_serial_out_oe_n = tdo_oe_n_q;
  assign id_par_out           = idr_par_q;

  // =====================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_IR_SHIFT:
    assert property (rise && trst_s_q && st_q == ST_SH_IR |=>
      ir_sh_q == {$past(link_s_q.tdi), $past(ir_sh_q[2:1])})
    else $error("instruction shift wrong");
  AST_IR_UPDATE:
    assert property (fall && trst_s_q && st_q == ST_UPD_IR |=>
      ir_par_q == $past(ir_sh_q))
    else $error("instruction not latched on update");
  AST_IR_CAPTURE:
    assert property (rise && trst_s_q && st_q == ST_CAP_IR |=>
      ir_sh_q == `BSJ_IR_CAPTURE)
    else $error("capture pattern missing");
  AST_TLR_IDCODE:
    assert property (st_q == ST_TLR |=> ir_par_q == `BSJ_OP_IDCODE)
    else $error("idcode not forced in reset state");
  AST_ID_CAPTURE:
    assert property (rise && trst_s_q && st_q == ST_CAP_DR &&
      ir_par_q == `BSJ_OP_IDCODE |=> idr_sh_q == ID_VALUE)
    else $error("identification not captured");
  AST_FSM_HOLD:
    assert property (!rise && trst_s_q |=> st_q == $past(st_q))
    else $error("state moved without a rise");
  AST_TRST:
    assert property (!trst_s_q |=> st_q == ST_TLR)
    else $error("test reset ignored");
  AST_TDO_FLOAT:
    assert property (fall && st_q != ST_SH_IR && st_q != ST_SH_DR |=>
      test_serial_out_oe_n)
    else $error("serial output driven outside shift");
  AST_BYPASS:
    assert property (rise && trst_s_q && st_q == ST_SH_DR &&
      ir_par_q == `BSJ_OP_BYPASS |=> byp_q == $past(link_s_q.tdi))
    else $error("bypass stage wrong");
  AST_HIGHZ:
    assert property (ir_par_q == `BSJ_OP_HIGHZ |=> pin_oe_n_q)
    else $error("outputs not floated");
  AST_EXTEST:
    assert property (ir_par_q == `BSJ_OP_EXTEST |=>
      pin_out_q == $past(bsr_par_q) && !pin_oe_n_q)
    else $error("extest drive wrong");
  AST_BSR_UPDATE:
    assert property (fall && trst_s_q && st_q == ST_UPD_DR &&
      ir_par_q == `BSJ_OP_SAMPLE |=> bsr_par_q == $past(bsr_sh_q))
    else $error("boundary update wrong");

  COV_IR_UPDATE:
    cover property (fall && st_q == ST_UPD_IR);
  COV_ID_SHIFT:
    cover property (rise && st_q == ST_SH_DR && dsel == SEL_IDR);
  COV_EXTEST:
    cover property (ir_par_q == `BSJ_OP_EXTEST && fall &&
      st_q == ST_UPD_DR);
endmodule // bsj_tap
`default_nettype wire

// ==== verif/bsj_ctl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// test controller model: clock stands low between periods
module bsj_ctl_model #(
  parameter int W = 160
) (
  // clock
  input  wire logic clk,
  // test access port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  logic tdo_s;
  logic oe_s;
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
    trst_n = 1'h0;
  end
  // one period; tms and tdi settle 4 clk before the rise
  task automatic tick(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'h1;
    repeat (2) @(posedge clk);
    tdo_s = tdo_oe_n ? ~tdo : tdo;
    oe_s = tdo_oe_n;
    repeat (2) @(posedge clk);
    tck <= 1'h0;
  endtask
  // scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [W-1:0] din,
                      output logic [W-1:0] dout, output logic bad);
    dout = '0;
    bad = 1'h0;
    tick(1'h1, ~tdi);
    if (ir)
      tick(1'h1, ~tdi);
    tick(1'h0, ~tdi);
    tick(1'h0, ~tdi);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i]);
      dout[i] = tdo_s;
      bad |= oe_s;
    end
    tick(1'h1, ~tdi);
    tick(1'h0, ~tdi);
  endtask
  // test reset pulse
  task automatic treset();
    trst_n <= 1'h0;
    repeat (4) @(posedge clk);
    trst_n <= 1'h1;
    repeat (4) @(posedge clk);
  endtask
endmodule // bsj_ctl_model
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "bsj_consts.svh"
module testbench;
  localparam int N = `BSJ_BSR_LEN;
  localparam int W = 160;
  localparam logic [31:0] ID =
    {`BSJ_ID_VERSION, `BSJ_ID_DEVICE, `BSJ_ID_MAKER, 1'h1};
  typedef struct packed {
    logic [2:0] code;
    logic       oe_in;
    logic       oe_ex;
    logic       bsr_pins;
    logic [1:0] dr;
  } bsj_row_s;
  // =====================================================
  // rows: code, core_oe_n, pin_oe_n, pins from bsr, data reg
  bsj_row_s rows [6] = '{
    '{3'h2, 1'h1, 1'h1, 1'h0, 2'h1},
    '{3'h0, 1'h1, 1'h0, 1'h1, 2'h1},
    '{3'h3, 1'h1, 1'h0, 1'h1, 2'h0},
    '{3'h4, 1'h0, 1'h1, 1'h0, 2'h0},
    '{3'h7, 1'h0, 1'h0, 1'h0, 2'h0},
    '{3'h1, 1'h0, 1'h0, 1'h0, 2'h2}
  };
  logic         clk = 1'h0;
  logic         rst_b = 1'h0;
  logic         tck, tms, tdi, trst_n, tdo, tdo_oe_n;
  logic [N-1:0] pin_in = {63{2'h2}};
  logic [N-1:0] core_out = {63{2'h1}};
  logic         core_oe_n = 1'h1;
  logic [N-1:0] pin_out, bsr_par;
  logic         pin_oe_n, bad;
  logic [31:0]  id_par_out;
  logic [W-1:0] din = {5{32'hC3A50F96}};
  logic [W-1:0] dout;
  int           n_fail = 0;
  int           checks_done = 0;
  always #12.5 clk = ~clk;
  bsj_tap i_bsj_tap (
    .clk(clk), .rst_b(rst_b), .test_clock_in(tck),
    .test_mode_select_in(tms), .test_serial_in(tdi), .test_reset_n(trst_n),
    .test_serial_out(tdo), .test_serial_out_oe_n(tdo_oe_n),
    .pin_in(pin_in), .core_out(core_out), .core_oe_n(core_oe_n),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .id_par_out(id_par_out)
  );
  bsj_ctl_model #(.W(W)) i_bsj_ctl_model (
    .clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n)
  );
  // =====================================================
  // helpers
  task automatic wrap_up();
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [W-1:0] exp,
                       input logic [W-1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_pins(input bsj_row_s r);
    check("pin_oe_n", W'(r.oe_ex), W'(pin_oe_n));
    check("pin_out", W'(r.bsr_pins ? bsr_par : core_out), W'(pin_out));
  endtask
  function automatic logic [W-1:0] dr_exp(input logic [1:0] k,
                                          input logic [W-1:0] d);
    case (k)
      2'h1: dr_exp = (d << N) | W'(pin_in);
      2'h2: dr_exp = (d << 32) | W'(ID);
      default: dr_exp = d << 1;
    endcase
  endfunction
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  // =====================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    i_bsj_ctl_model.treset();
    check("pin_out", W'(core_out), W'(pin_out));
    check("pin_oe_n", W'(core_oe_n), W'(pin_oe_n));
    check("id_par_out", '0, W'(id_par_out));
    i_bsj_ctl_model.tick(1'h0, 1'h1);
    foreach (rows[r])
    begin
      core_oe_n <= rows[r].oe_in;
      i_bsj_ctl_model.scan(1'h1, 3, W'(rows[r].code), dout, bad);
      check("ir_capture", W'(3'h1), dout);
      check("shift_oe_n", '0, W'(bad));
      check("idle_oe_n", W'(1'h1), W'(tdo_oe_n));
      check_pins(rows[r]);
      i_bsj_ctl_model.scan(1'h0, W, din, dout, bad);
      check("dr_out", dr_exp(rows[r].dr, din), dout);
      if (rows[r].dr == 2'h1)
        bsr_par = din[W-1 -: N];
      if (rows[r].dr == 2'h2)
        check("id_par_out", W'(din[W-1 -: 32]), W'(id_par_out));
      check_pins(rows[r]);
      din = {din[W-6:0], din[W-1 -: 5]};
    end
    // test reset mid-run after bypass is current
    i_bsj_ctl_model.scan(1'h1, 3, W'(3'h7), dout, bad);
    i_bsj_ctl_model.treset();
    check("pin_oe_n", W'(core_oe_n), W'(pin_oe_n));
    i_bsj_ctl_model.tick(1'h0, 1'h0);
    i_bsj_ctl_model.scan(1'h0, W, din, dout, bad);
    check("dr_after_reset", dr_exp(2'h2, din), dout);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
